// *** src/ldpc_core.sv ***
// Behaviour
// - a low kill input puts every line driver in high impedance, whatever else holds.
// - hold-active and kill both high keep all drivers active regardless of levels or edges.
// - hold-active low and kill high keep drivers active while an edge occurred in the last 30 s.
// - hold-active low and kill high turn drivers off once no edge has been seen for 30 s.
// - hold-active tied to the signal-present flag with kill high enables drivers on valid level or recent edge.
// - both controls tied to the signal-present flag enable drivers only while a valid level is present.
// - receiver outputs stay active in every state, shutdown included.
// - the signal-present flag is high whenever a valid level is on the receiver inputs, independent of control.
// - after idle shutdown any receiver or transmitter edge re-enables the drivers at once.
module ldpc_core #(
  parameter longint unsigned IDLE_CYCLES = ldpc_pkg::IDLE_CYCLES
) (
  input  wire logic                        clk_in,
  input  wire logic                        reset_in,
  input  wire logic                        clk_en_in,
  input  wire logic                        hold_active_in,
  input  wire logic                        kill_in,
  input  wire logic [ldpc_pkg::NUM_RX-1:0] rx_line_in,
  input  wire logic [ldpc_pkg::NUM_RX-1:0] rx_level_valid_in,
  input  wire logic [ldpc_pkg::NUM_TX-1:0] tx_data_in,
  output logic      [ldpc_pkg::NUM_RX-1:0] rx_data_out,
  output logic                             signal_present_out,
  output logic                             drivers_active_out,
  output logic      [ldpc_pkg::NUM_TX-1:0] tx_drive_out,
  output logic      [ldpc_pkg::NUM_TX-1:0] tx_drive_en_out,
  output logic      [ldpc_pkg::NUM_RX-1:0] rx_out_en_out
);
  localparam int unsigned EDGE_W = ldpc_pkg::NUM_RX + ldpc_pkg::NUM_TX;
  localparam int unsigned IN_W   = EDGE_W + ldpc_pkg::NUM_RX + 2;
  localparam int unsigned CNT_W  = ldpc_pkg::TIMER_W;
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);

  logic [IN_W-1:0]             sync1_q;
  logic [IN_W-1:0]             sync2_q;
  logic [EDGE_W-1:0]           edge_prev_q;
  logic [2:0]                  warm_q;
  logic [CNT_W-1:0]            idle_cnt_q;
  logic                        recent_q;
  logic                        present_q;
  logic                        drv_q;
  logic [ldpc_pkg::NUM_RX-1:0] rx_data_q;
  logic [ldpc_pkg::NUM_TX-1:0] tx_data_q;
  logic                        hold_s;
  logic                        kill_s;
  logic [ldpc_pkg::NUM_RX-1:0] valid_s;
  logic [EDGE_W-1:0]           lines_s;
  logic                        edge_seen;
  logic                        drv_d;

  // timer sits on its last count
  function automatic logic idle_expired(input logic [CNT_W-1:0] cnt);
    return cnt == IDLE_LAST;
  endfunction

  // two-flop synchronisers, one per pin bit, no logic in front
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en_in) begin
      sync1_q <= {hold_active_in, kill_in, rx_level_valid_in, rx_line_in, tx_data_in};
      sync2_q <= sync1_q;
    end
  end

  assign hold_s  = sync2_q[IN_W-1];
  assign kill_s  = sync2_q[IN_W-2];
  assign valid_s = sync2_q[IN_W-3 -: ldpc_pkg::NUM_RX];
  assign lines_s = sync2_q[EDGE_W-1:0];

  // edge history trusted only once it holds real pin samples
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      warm_q <= '0;
    end else if (clk_en_in) begin
      warm_q <= {warm_q[1:0], 1'h1};
    end
  end

  // previous synced levels for edge detection
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      edge_prev_q <= '0;
    end else if (clk_en_in) begin
      edge_prev_q <= lines_s;
    end
  end

  assign edge_seen = warm_q[2] & |(edge_prev_q ^ lines_s);

  // idle timer, restarted by any edge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      idle_cnt_q <= '0;
      recent_q   <= 1'h0;
    end else if (clk_en_in) begin
      if (edge_seen) begin
        idle_cnt_q <= '0;
        recent_q   <= 1'h1;
      end else if (recent_q) begin
        if (idle_expired(idle_cnt_q)) begin
          recent_q   <= 1'h0;
          idle_cnt_q <= '0;
        end else begin
          idle_cnt_q <= idle_cnt_q + 1'h1;
        end
      end
    end
  end

  // flag reflects receiver levels only, never the controls
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      present_q <= 1'h0;
    end else if (clk_en_in) begin
      present_q <= |valid_s;
    end
  end

  // driver enable; wiring of controls to the flag gives modes
  always_comb begin
    if (!kill_s) begin
      drv_d = 1'h0;
    end else if (hold_s) begin
      drv_d = 1'h1;
    end else begin
      drv_d = recent_q | edge_seen;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      drv_q <= 1'h0;
    end else if (clk_en_in) begin
      drv_q <= drv_d;
    end
  end

  // receivers and transmitters both invert
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_data_q <= '1;
      tx_data_q <= '1;
    end else if (clk_en_in) begin
      rx_data_q <= ~lines_s[EDGE_W-1:ldpc_pkg::NUM_TX];
      tx_data_q <= ~lines_s[ldpc_pkg::NUM_TX-1:0];
    end
  end

  assign drivers_active_out = drv_q;
  assign tx_drive_en_out    = {ldpc_pkg::NUM_TX{drv_q}};
  assign tx_drive_out       = tx_data_q;
  assign rx_data_out        = rx_data_q;
  assign rx_out_en_out      = '1;
  assign signal_present_out = present_q;

  // checks
  chk_kill_forces_off:
    assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && !kill_s |=> !drivers_active_out)
    else $error("drivers active after kill low");

  chk_kill_pin_off:
    assert property (@(posedge clk_in) disable iff (reset_in)
      (clk_en_in && !kill_in) [*3] |=> !drivers_active_out)
    else $error("drivers active after kill pin low");

  chk_hold_forces_on:
    assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && kill_s && hold_s |=> drivers_active_out)
    else $error("drivers off while held active");

  chk_edge_wakes:
    assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && kill_s && edge_seen |=> drivers_active_out)
    else $error("edge did not wake drivers");

  chk_no_false_wake:
    assert property (@(posedge clk_in) disable iff (reset_in)
      !warm_q[2] |=> !recent_q)
    else $error("edge seen before history settled");

  chk_edge_restarts:
    assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && edge_seen |=> idle_cnt_q == '0 && recent_q)
    else $error("timer not restarted");

  chk_idle_expiry:
    assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && recent_q && !edge_seen && idle_expired(idle_cnt_q) |=> !recent_q)
    else $error("timer did not expire");

  chk_recent_holds:
    assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && kill_s && recent_q |=> drivers_active_out)
    else $error("drivers off inside interval");

  chk_rx_active:
    assert property (@(posedge clk_in) disable iff (reset_in)
      rx_out_en_out == '1)
    else $error("receiver output disabled");

  chk_flag_follows:
    assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in ##1 clk_en_in ##1 clk_en_in ##1 clk_en_in |-> signal_present_out == $past(|rx_level_valid_in, 3))
    else $error("flag not following level");

  chk_idle_off:
    assert property (@(posedge clk_in) disable iff (reset_in)
      clk_en_in && kill_s && !hold_s && !recent_q && !edge_seen |=> !drivers_active_out)
    else $error("drivers on while idle");

  // scenarios reached
  cov_forced_off:
    cover property (@(posedge clk_in) disable iff (reset_in) !kill_s ##1 !drivers_active_out);
  cov_idle_sleep:
    cover property (@(posedge clk_in) disable iff (reset_in) $fell(recent_q));
  cov_wake:
    cover property (@(posedge clk_in) disable iff (reset_in) !drivers_active_out ##1 drivers_active_out);
  cov_timer_restart:
    cover property (@(posedge clk_in) disable iff (reset_in) recent_q && edge_seen);
  cov_flag_rise:
    cover property (@(posedge clk_in) disable iff (reset_in) $rose(signal_present_out));
endmodule

// *** inc/ldpc_pkg.sv ***
package ldpc_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned IDLE_SECONDS  = 30;
  // cycles in one idle interval
  localparam longint unsigned IDLE_CYCLES = longint'(IDLE_SECONDS) * longint'(CLK_HZ);
  localparam int unsigned NUM_TX        = 3;
  localparam int unsigned NUM_RX        = 3;
  localparam int unsigned TIMER_W       = 31;
endpackage

// *** dv/ldpc_host.sv ***
module ldpc_host (
  input  wire logic [1:0] mode_in,
  input  wire logic       sleep_in,
  input  wire logic       present_in,
  output logic            hold_active_out,
  output logic            kill_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // 0 sleep line, 1 hold on flag, 2 both on flag, 3 auto
  always_comb begin
    case (mode_in)
      2'h0: {hold_active_out, kill_out} = {sleep_in, sleep_in};
      2'h1: {hold_active_out, kill_out} = {present_in, 1'h1};
      2'h2: {hold_active_out, kill_out} = {present_in, present_in};
      default: {hold_active_out, kill_out} = 2'h1;
    endcase
  end
endmodule

// *** dv/ldpc_core_bench.sv ***
module ldpc_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_in = 1'h0, reset_in = 1'h1, sleep = 1'h0, en = 1'h1, hold, kill, pres, act;
  logic [1:0] mode = 2'h0;
  logic [2:0] rxl = 3'h0, rxv = 3'h0, txd = 3'h0, rxd, txo, txe, rxe;
  int         mismatches = 0, checks_done = 0;
  initial forever #12.5 clk_in = ~clk_in;
  ldpc_core #(.IDLE_CYCLES(20)) u_ldpc_core (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(en),
    .hold_active_in(hold), .kill_in(kill), .rx_line_in(rxl), .rx_level_valid_in(rxv), .tx_data_in(txd),
    .rx_data_out(rxd), .signal_present_out(pres), .drivers_active_out(act), .tx_drive_out(txo),
    .tx_drive_en_out(txe), .rx_out_en_out(rxe));
  ldpc_host u_ldpc_host (.mode_in(mode), .sleep_in(sleep), .present_in(pres), .hold_active_out(hold),
    .kill_out(kill));
  task automatic check(input string nm, input logic [2:0] exp, input logic [2:0] seen);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic set(input logic [1:0] m, input logic s, input logic [2:0] v, input int n);
    mode = m;
    sleep = s;
    rxv = v;
    repeat (n) @(negedge clk_in);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // forced on, then forced off
  task automatic forced();
    set(2'h0, 1'h1, 3'h0, 5);
    check("drv_en", 3'h7, txe);
    set(2'h0, 1'h0, 3'h7, 5);
    check("drv_en", 3'h0, txe);
    check("rx_en", 3'h7, rxe);
  endtask
  // idle timer wake, restart and expiry
  task automatic auto_idle();
    set(2'h3, 1'h0, 3'h0, 25);
    check("act", 3'h0, {2'h0, act});
    txd = 3'h1;
    set(2'h3, 1'h0, 3'h0, 12);
    check("act", 3'h1, {2'h0, act});
    check("tx_drive", 3'h6, txo);
    rxl = 3'h4;
    set(2'h3, 1'h0, 3'h0, 18);
    check("act", 3'h1, {2'h0, act});
    check("rx_data", 3'h3, rxd);
    set(2'h3, 1'h0, 3'h0, 12);
    check("act", 3'h0, {2'h0, act});
  endtask
  // controls following the present flag
  task automatic flag_modes();
    set(2'h1, 1'h0, 3'h2, 8);
    check("pres", 3'h1, {2'h0, pres});
    check("act", 3'h1, {2'h0, act});
    set(2'h1, 1'h0, 3'h0, 30);
    check("act", 3'h0, {2'h0, act});
    set(2'h2, 1'h0, 3'h1, 8);
    check("act", 3'h1, {2'h0, act});
    txd = 3'h0;
    set(2'h2, 1'h0, 3'h0, 8);
    check("act", 3'h0, {2'h0, act});
  endtask
  // clock enable low holds every register
  task automatic frozen();
    en = 1'h0;
    set(2'h0, 1'h1, 3'h0, 6);
    check("act", 3'h0, {2'h0, act});
    en = 1'h1;
    set(2'h0, 1'h1, 3'h0, 5);
    check("act", 3'h1, {2'h0, act});
  endtask
  initial begin
    repeat (3) @(negedge clk_in);
    reset_in = 1'h0;
    forced();
    auto_idle();
    flag_modes();
    frozen();
    complete_run();
  end
  initial begin
    #25000;
    mismatches++;
    complete_run();
  end
endmodule
